// *** shared/gpc_defs.svh ***
`ifndef GPC_DEFS_SVH
`define GPC_DEFS_SVH

// ====================================================================
// register offsets on the management register port
`define GPC_OFS_PIN1_CFG     8'h03
`define GPC_OFS_PIN2_CFG     8'h04
`define GPC_OFS_READBACK     8'h05
`define GPC_OFS_DRIVE        8'h06

// ====================================================================
// configuration register field positions (both pins)
`define GPC_FUNC_MSB         7
`define GPC_FUNC_LSB         4
`define GPC_PULL_MSB         3
`define GPC_PULL_LSB         2
`define GPC_IBUF_BIT         1
`define GPC_OE_BIT           0

// ====================================================================
// reset values
`define GPC_PIN1_CFG_RST     8'h05
`define GPC_PIN2_CFG_RST     8'h04
`define GPC_DRIVE_RST        3'h0
`define GPC_DRIVE_W          3

// ====================================================================
// readback and drive bit positions
`define GPC_BIT_PIN0         0
`define GPC_BIT_PIN1         1
`define GPC_BIT_PIN2         2

// ====================================================================
// positions in the synchronised input vector
`define GPC_SY_PIN0          0
`define GPC_SY_PIN1          1
`define GPC_SY_PIN2          2
`define GPC_SY_POR           3
`define GPC_SY_PLL           4
`define GPC_SY_LOS_LSB       5
`define GPC_SY_LOS_MSB       9
`define GPC_SY_SERCLK        10
`define GPC_SY_PARCLK        11
`define GPC_SY_TRANSMIT_CLOCK_INPUT         12
`define GPC_SY_W             13

`endif

// *** shared/gpc_pkg.sv ***
`default_nettype none
package gpc_pkg;

  // ==================================================================
  // function select codes, pin 1
  typedef enum logic [3:0] {
    GPC_F1_POR   = 4'b0000,
    GPC_F1_DRIVE = 4'b0001,
    GPC_F1_PLL   = 4'b0010,
    GPC_F1_LOS0  = 4'b0100,
    GPC_F1_LOS1  = 4'b0101,
    GPC_F1_LOS2  = 4'b0110,
    GPC_F1_LOS3  = 4'b0111,
    GPC_F1_LOS4  = 4'b1000
  } gpc_pin1_func_e;

  // function select codes, pin 2
  typedef enum logic [3:0] {
    GPC_F2_DRIVE  = 4'b0000,
    GPC_F2_ON     = 4'b0001,
    GPC_F2_SERCLK = 4'b0010,
    GPC_F2_PARCLK = 4'b0011,
    GPC_F2_TRANSMIT_CLOCK_INPUT  = 4'b0100
  } gpc_pin2_func_e;

  // pull resistor codes; 2'b11 reserved
  typedef enum logic [1:0] {
    GPC_PULL_OFF  = 2'b00,
    GPC_PULL_DOWN = 2'b01,
    GPC_PULL_UP   = 2'b10
  } gpc_pull_e;

  typedef logic [4:0] gpc_lanes_t;
  typedef logic [7:0] gpc_byte_t;

endpackage : gpc_pkg
`default_nettype wire

// *** shared/gpc_sync_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// ====================================================================
// carrier between the top and its input synchroniser
interface gpc_sync_if #(
  parameter int W = 13
);
  logic [W-1:0] raw;
  logic [W-1:0] sync;
  modport src    (output raw, input sync);
  modport syncer (input raw, output sync);
endinterface : gpc_sync_if
`default_nettype wire

// *** logic/gpc_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
// ====================================================================
// two-stage synchroniser for every asynchronous input bit
module gpc_sync #(
  parameter int W = 13
) (
  input  wire logic     clock,
  input  wire logic     sys_rst,
  gpc_sync_if.syncer    sy
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // first stage feeds only the second stage
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clock) begin
        if (sys_rst) begin
          meta_q[i] <= 1'b0;
          sync_q[i] <= 1'b0;
        end else begin
          meta_q[i] <= sy.raw[i];
          sync_q[i] <= meta_q[i];
        end
      end
    end
  endgenerate

  assign sy.sync = sync_q;

endmodule : gpc_sync
`default_nettype wire

// *** logic/gpc_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "gpc_defs.svh"

// Functional notes
// - pin 1 function bits 7:4: 0000 reset, 0001 drive bit, 0010 lock
// - pin 1 codes 0100..1000 route lane 0..4 signal loss
// - pin 2 function: drive bit, constant high, three clocks
// - pull field bits 3:2: off, pull-down, pull-up; resets to pull-down
// - bit 1 enables the input buffer; resets disabled
// - pin 1 bit 0 enables its driver; resets enabled
// - pin 2 bit 0 enables its driver; resets disabled
// - readback register shows pins 2,1,0 in bits 2,1,0; rest zero
// - drive register bits 2..0 read/write, reset 0; bits 2,1 supply pin 2,1 levels, bit 0 drives nothing
// - readback is read-only and carries sampled levels of input pins
module gpc_top (
  input  wire logic              clock,
  input  wire logic              sys_rst,
  input  wire logic [7:0]        reg_addr,
  input  wire logic              reg_wr_en,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_rd_en,
  output var  gpc_pkg::gpc_byte_t reg_rdata,
  output var  logic              reg_rd_valid,
  input  wire logic              pin0_in,
  input  wire logic              pin1_in,
  input  wire logic              pin2_in,
  input  wire logic              pin0_input_enable,
  input  wire logic              power_on_reset,
  input  wire logic              pll_locked,
  input  wire gpc_pkg::gpc_lanes_t lane_signal_lost,
  input  wire logic              serializer_clock,
  input  wire logic              parallel_clock,
  input  wire logic              transmit_clock_input,
  output var  logic              pin1_out,
  output var  logic              pin1_output_driver_enable,
  output var  logic              pin1_pull_up,
  output var  logic              pin1_pull_down,
  output var  logic              pin1_input_buffer_enable,
  output var  logic              pin2_out,
  output var  logic              pin2_output_driver_enable,
  output var  logic              pin2_pull_up,
  output var  logic              pin2_pull_down,
  output var  logic              pin2_input_buffer_enable
);
  import gpc_pkg::*;

  // ==================================================================
  // decode helpers
  // reserved pull code falls back to no pull at all
  function automatic logic [1:0] pull_decode(input logic [1:0] code);
    logic [1:0] r;
    r = 2'b00;
    case (code)
      GPC_PULL_DOWN: r = 2'b01;
      GPC_PULL_UP:   r = 2'b10;
      default:       r = 2'b00;
    endcase
    return r;
  endfunction : pull_decode

  // ==================================================================
  // input synchronisation
  // sampled clocks are only meaningful well below the core rate
  gpc_sync_if #(.W(`GPC_SY_W)) sy ();

  assign sy.raw = {transmit_clock_input, parallel_clock, serializer_clock,
                   lane_signal_lost, pll_locked, power_on_reset,
                   pin2_in, pin1_in, pin0_in};

  gpc_sync #(.W(`GPC_SY_W)) u_sync (
    .clock   (clock),
    .sys_rst (sys_rst),
    .sy      (sy)
  );

  // ==================================================================
  // register storage
  gpc_byte_t                 pin1_cfg_q;
  gpc_byte_t                 pin2_cfg_q;
  logic [`GPC_DRIVE_W-1:0]   drive_q;
  gpc_byte_t                 rdata_q;
  logic                      rd_valid_q;

  // write decode
  wire logic wr_pin1  = reg_wr_en && (reg_addr == `GPC_OFS_PIN1_CFG);
  wire logic wr_pin2  = reg_wr_en && (reg_addr == `GPC_OFS_PIN2_CFG);
  wire logic wr_drive = reg_wr_en && (reg_addr == `GPC_OFS_DRIVE);

  // configuration fields
  wire logic [3:0] pin1_func = pin1_cfg_q[`GPC_FUNC_MSB:`GPC_FUNC_LSB];
  wire logic [3:0] pin2_func = pin2_cfg_q[`GPC_FUNC_MSB:`GPC_FUNC_LSB];
  wire logic [1:0] pin1_pull = pin1_cfg_q[`GPC_PULL_MSB:`GPC_PULL_LSB];
  wire logic [1:0] pin2_pull = pin2_cfg_q[`GPC_PULL_MSB:`GPC_PULL_LSB];
  wire logic pin1_ibuf = pin1_cfg_q[`GPC_IBUF_BIT];
  wire logic pin2_ibuf = pin2_cfg_q[`GPC_IBUF_BIT];

  // configuration and drive registers; readback has no storage
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pin1_cfg_q <= `GPC_PIN1_CFG_RST;
      pin2_cfg_q <= `GPC_PIN2_CFG_RST;
      drive_q    <= `GPC_DRIVE_RST;
    end else begin
      if (wr_pin1) pin1_cfg_q <= reg_wdata;
      if (wr_pin2) pin2_cfg_q <= reg_wdata;
      if (wr_drive) drive_q <= reg_wdata[`GPC_DRIVE_W-1:0];
    end
  end

  // ==================================================================
  // synchronised sources
  wire logic       s_por    = sy.sync[`GPC_SY_POR];
  wire logic       s_pll    = sy.sync[`GPC_SY_PLL];
  wire gpc_lanes_t s_los    = sy.sync[`GPC_SY_LOS_MSB:`GPC_SY_LOS_LSB];
  wire logic       s_serclk = sy.sync[`GPC_SY_SERCLK];
  wire logic       s_parclk = sy.sync[`GPC_SY_PARCLK];
  wire logic       s_transmit_clock_input  = sy.sync[`GPC_SY_TRANSMIT_CLOCK_INPUT];

  // readback gated by each pin's input buffer enable
  wire logic [2:0] pin_levels = {
    sy.sync[`GPC_SY_PIN2] & pin2_ibuf,
    sy.sync[`GPC_SY_PIN1] & pin1_ibuf,
    sy.sync[`GPC_SY_PIN0] & pin0_input_enable
  };

  // ==================================================================
  // output source selection
  logic pin1_src;
  logic pin2_src;

  // pin 1 source; reserved codes fall back to the drive bit
  always_comb begin
    case (pin1_func)
      GPC_F1_POR:   pin1_src = s_por;
      GPC_F1_DRIVE: pin1_src = drive_q[`GPC_BIT_PIN1];
      GPC_F1_PLL:   pin1_src = s_pll;
      GPC_F1_LOS0:  pin1_src = s_los[0];
      GPC_F1_LOS1:  pin1_src = s_los[1];
      GPC_F1_LOS2:  pin1_src = s_los[2];
      GPC_F1_LOS3:  pin1_src = s_los[3];
      GPC_F1_LOS4:  pin1_src = s_los[4];
      default:      pin1_src = drive_q[`GPC_BIT_PIN1];
    endcase
  end

  // pin 2 source; clocks pass sampled, not as true clocks
  always_comb begin
    case (pin2_func)
      GPC_F2_DRIVE:  pin2_src = drive_q[`GPC_BIT_PIN2];
      GPC_F2_ON:     pin2_src = 1'b1;
      GPC_F2_SERCLK: pin2_src = s_serclk;
      GPC_F2_PARCLK: pin2_src = s_parclk;
      GPC_F2_TRANSMIT_CLOCK_INPUT:  pin2_src = s_transmit_clock_input;
      default:       pin2_src = drive_q[`GPC_BIT_PIN2];
    endcase
  end

  wire logic [1:0] pin1_pulls = pull_decode(pin1_pull);
  wire logic [1:0] pin2_pulls = pull_decode(pin2_pull);

  // ==================================================================
  // pad-facing output flops
  logic pin1_out_q, pin1_oe_q, pin1_pu_q, pin1_pd_q, pin1_ib_q;
  logic pin2_out_q, pin2_oe_q, pin2_pu_q, pin2_pd_q, pin2_ib_q;

  // reset values mirror the configuration reset values
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pin1_out_q <= 1'b0;
      pin1_oe_q  <= 1'b1;
      pin1_pu_q  <= 1'b0;
      pin1_pd_q  <= 1'b1;
      pin1_ib_q  <= 1'b0;
      pin2_out_q <= 1'b0;
      pin2_oe_q  <= 1'b0;
      pin2_pu_q  <= 1'b0;
      pin2_pd_q  <= 1'b1;
      pin2_ib_q  <= 1'b0;
    end else begin
      pin1_out_q <= pin1_src;
      pin1_oe_q  <= pin1_cfg_q[`GPC_OE_BIT];
      pin1_pu_q  <= pin1_pulls[1];
      pin1_pd_q  <= pin1_pulls[0];
      pin1_ib_q  <= pin1_ibuf;
      pin2_out_q <= pin2_src;
      pin2_oe_q  <= pin2_cfg_q[`GPC_OE_BIT];
      pin2_pu_q  <= pin2_pulls[1];
      pin2_pd_q  <= pin2_pulls[0];
      pin2_ib_q  <= pin2_ibuf;
    end
  end

  // ==================================================================
  // register read path; unmapped offsets answer zero
  logic [7:0] rd_mux;
  always_comb begin
    case (reg_addr)
      `GPC_OFS_PIN1_CFG: rd_mux = pin1_cfg_q;
      `GPC_OFS_PIN2_CFG: rd_mux = pin2_cfg_q;
      `GPC_OFS_READBACK: rd_mux = {5'h00, pin_levels};
      `GPC_OFS_DRIVE:    rd_mux = {5'h00, drive_q};
      default:           rd_mux = 8'h00;
    endcase
  end

  // data held until the next read so a slow master can take it
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rdata_q    <= 8'h00;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= reg_rd_en;
      if (reg_rd_en) rdata_q <= rd_mux;
    end
  end

  assign reg_rdata                 = rdata_q;
  assign reg_rd_valid              = rd_valid_q;
  assign pin1_out                  = pin1_out_q;
  assign pin1_output_driver_enable = pin1_oe_q;
  assign pin1_pull_up              = pin1_pu_q;
  assign pin1_pull_down            = pin1_pd_q;
  assign pin1_input_buffer_enable  = pin1_ib_q;
  assign pin2_out                  = pin2_out_q;
  assign pin2_output_driver_enable = pin2_oe_q;
  assign pin2_pull_up              = pin2_pu_q;
  assign pin2_pull_down            = pin2_pd_q;
  assign pin2_input_buffer_enable  = pin2_ib_q;

  // ==================================================================
  // assertions
  sequence s_wr_pin1;
    wr_pin1;
  endsequence

  sequence s_wr_drive;
    wr_drive;
  endsequence

  sequence s_rd_drive;
    reg_rd_en && (reg_addr == `GPC_OFS_DRIVE);
  endsequence

  AST_PIN1_BASIC: assert property (
    @(posedge clock) disable iff (sys_rst)
    (pin1_func == 4'h0) |=> (pin1_out == $past(s_por)))
    else $error("pin 1 does not follow the reset indication");

  AST_PIN1_LOSS: assert property (
    @(posedge clock) disable iff (sys_rst)
    (pin1_func == 4'h6) |=> (pin1_out == $past(s_los[2])))
    else $error("pin 1 does not follow lane 2 signal loss");

  AST_PIN2_ON: assert property (
    @(posedge clock) disable iff (sys_rst)
    (pin2_func == 4'h1) |=> pin2_out)
    else $error("pin 2 constant level not driven");

  AST_PULL: assert property (
    @(posedge clock) disable iff (sys_rst)
    (pin1_pull == 2'b10) |=> (pin1_pull_up && !pin1_pull_down))
    else $error("pin 1 pull-up not applied");

  AST_IBUF: assert property (
    @(posedge clock) disable iff (sys_rst)
    s_wr_pin1 ##1 1'b1 |=>
      (pin1_input_buffer_enable == $past(reg_wdata[1], 2)))
    else $error("pin 1 input buffer enable does not follow write");

  AST_PIN1_OE_RST: assert property (
    @(posedge clock)
    $fell(sys_rst) |-> pin1_output_driver_enable && pin1_pull_down)
    else $error("pin 1 driver not enabled after reset");

  AST_PIN2_OE_RST: assert property (
    @(posedge clock)
    $fell(sys_rst) |-> !pin2_output_driver_enable
      && !pin2_input_buffer_enable)
    else $error("pin 2 driver enabled after reset");

  AST_READBACK: assert property (
    @(posedge clock) disable iff (sys_rst)
    reg_rd_en && (reg_addr == `GPC_OFS_READBACK) |=>
      reg_rd_valid && (reg_rdata[7:3] == 5'h00)
      && (reg_rdata[1] == $past(sy.sync[`GPC_SY_PIN1] & pin1_ibuf)))
    else $error("readback register value wrong");

  AST_DRIVE_RW: assert property (
    @(posedge clock) disable iff (sys_rst)
    s_wr_drive ##1 s_rd_drive |=>
      (reg_rdata == {5'h00, $past(reg_wdata[2:0], 2)}))
    else $error("drive register read does not return written value");

  AST_RO: assert property (
    @(posedge clock) disable iff (sys_rst)
    reg_wr_en && (reg_addr == `GPC_OFS_READBACK) |=>
      $stable(pin1_cfg_q) && $stable(pin2_cfg_q) && $stable(drive_q))
    else $error("write to readback register changed state");

  AST_RESERVED_CODE: assert property (
    @(posedge clock) disable iff (sys_rst)
    (pin1_func == 4'h3) |=> (pin1_out == $past(drive_q[1])))
    else $error("reserved pin 1 code does not use drive bit");

endmodule : gpc_top
`default_nettype wire

// *** dv/gpc_pad_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ====================================================================
// board side of one pad: outside driver, pull resistors, open level
module gpc_pad_model (
  input  wire logic clock,
  input  wire logic dev_oe,
  input  wire logic dev_val,
  input  wire logic pull_up,
  input  wire logic pull_down,
  input  wire logic ext_en,
  input  wire logic ext_val,
  output var  logic pad
);
  logic float_q;

  // an open pad toggles so a stale level never passes for a read
  always @(posedge clock) begin
    float_q <= (float_q === 1'b1) ? 1'b0 : 1'b1;
  end

  // an enabled device driver wins; with ext_en set the board drives a tristated pin, else the pulls
  always_comb begin
    if (dev_oe === 1'b1) pad = dev_val;
    else if (ext_en === 1'b1) pad = ext_val;
    else if (pull_up === 1'b1) pad = 1'b1;
    else if (pull_down === 1'b1) pad = 1'b0;
    else pad = float_q;
  end
endmodule : gpc_pad_model
`default_nettype wire

// *** dv/general_purpose_pin_config_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "gpc_defs.svh"

`define CHK(nm, e, g) \
  begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected %s exp=%h got=%h", nm, e, g); end end

// ====================================================================
// self-checking bench for the pin configuration block
module general_purpose_pin_config_bench;
  import gpc_pkg::*;
  logic clock, sys_rst, reg_wr_en, reg_rd_en, reg_rd_valid;
  logic [7:0] reg_addr, reg_wdata;
  gpc_byte_t reg_rdata;
  logic pin0_in, pin1_in, pin2_in, pin0_input_enable;
  logic power_on_reset, pll_locked;
  gpc_lanes_t lane_signal_lost;
  logic serializer_clock, parallel_clock, transmit_clock_input;
  logic pin1_out, pin1_output_driver_enable, pin1_pull_up, pin1_pull_down;
  logic pin2_out, pin2_output_driver_enable, pin2_pull_up, pin2_pull_down;
  logic pin1_input_buffer_enable, pin2_input_buffer_enable;
  logic [1:0] ext_en, ext_val;
  logic [15:0] a, b;
  logic [7:0] c1, c2, wd, d;
  logic e1, e2, p1, p2;
  logic [3:0] v;
  int n_mismatch, n_tests;

  gpc_top gpc_top_inst (.clock(clock), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata),
    .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .pin0_in(pin0_in), .pin1_in(pin1_in),
    .pin2_in(pin2_in), .pin0_input_enable(pin0_input_enable),
    .power_on_reset(power_on_reset), .pll_locked(pll_locked),
    .lane_signal_lost(lane_signal_lost),
    .serializer_clock(serializer_clock), .parallel_clock(parallel_clock),
    .transmit_clock_input(transmit_clock_input), .pin1_out(pin1_out),
    .pin1_output_driver_enable(pin1_output_driver_enable),
    .pin1_pull_up(pin1_pull_up), .pin1_pull_down(pin1_pull_down),
    .pin1_input_buffer_enable(pin1_input_buffer_enable),
    .pin2_out(pin2_out),
    .pin2_output_driver_enable(pin2_output_driver_enable),
    .pin2_pull_up(pin2_pull_up), .pin2_pull_down(pin2_pull_down),
    .pin2_input_buffer_enable(pin2_input_buffer_enable));

  // ==================================================================
  // board pads in front of pins 1 and 2
  gpc_pad_model pad1_inst (.clock(clock),
    .dev_oe(pin1_output_driver_enable), .dev_val(pin1_out),
    .pull_up(pin1_pull_up), .pull_down(pin1_pull_down),
    .ext_en(ext_en[0]), .ext_val(ext_val[0]), .pad(pin1_in));
  gpc_pad_model pad2_inst (.clock(clock),
    .dev_oe(pin2_output_driver_enable), .dev_val(pin2_out),
    .pull_up(pin2_pull_up), .pull_down(pin2_pull_down),
    .ext_en(ext_en[1]), .ext_val(ext_val[1]), .pad(pin2_in));

  // ==================================================================
  // expectations
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  function automatic logic exp_p1(input logic [3:0] f, input logic dv,
                                  input logic por, input logic pll,
                                  input logic [4:0] los);
    case (f)
      4'h0: return por;
      4'h2: return pll;
      4'h4, 4'h5, 4'h6, 4'h7, 4'h8: return los[f - 4'h4];
      default: return dv;
    endcase
  endfunction : exp_p1

  function automatic logic exp_p2(input logic [3:0] f, input logic dv,
                                  input logic [2:0] clks);
    case (f)
      4'h1: return 1'b1;
      4'h2: return clks[0];
      4'h3: return clks[1];
      4'h4: return clks[2];
      default: return dv;
    endcase
  endfunction : exp_p2

  // reserved pull code behaves like pulls off
  function automatic logic [1:0] exp_pull(input logic [1:0] p);
    return {p == 2'b10, p == 2'b01};
  endfunction : exp_pull

  // ==================================================================
  // register port; an idle cycle after each strobe keeps drivers clean
  task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
    reg_addr <= ad;
    reg_wdata <= dt;
    reg_wr_en <= 1'b1;
    @(posedge clock); #1;
    reg_wr_en <= 1'b0;
    @(posedge clock); #1;
  endtask : wr

  task automatic rd_chk(input logic [7:0] ad, input logic [7:0] e,
                        input string nm);
    int n;
    reg_addr <= ad;
    reg_rd_en <= 1'b1;
    @(posedge clock); #1;
    reg_rd_en <= 1'b0;
    n = 0;
    while (reg_rd_valid !== 1'b1 && n < 8) begin
      @(posedge clock); #1;
      n++;
    end
    `CHK("rd valid", 1'b1, reg_rd_valid);
    `CHK(nm, e, reg_rdata);
    @(posedge clock); #1;
  endtask : rd_chk

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // whole run is under 400 cycles; more than twelve times that is a hang
  initial begin
    repeat (5000) @(posedge clock);
    n_mismatch++;
    wrap_up();
  end

  // ==================================================================
  // main sequence
  initial begin
    {reg_wr_en, reg_rd_en, pin0_in, pin0_input_enable} = 4'h0;
    {power_on_reset, pll_locked, serializer_clock} = 3'h0;
    {parallel_clock, transmit_clock_input} = 2'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    lane_signal_lost = 5'h00;
    ext_en = 2'h0;
    ext_val = 2'h0;
    n_mismatch = 0;
    n_tests = 0;
    a = 16'h0313;  // seed 787
    sys_rst = 1'b1;
    repeat (5) @(posedge clock);
    #1 sys_rst <= 1'b0;
    v = {2'h0, pin2_output_driver_enable, pin1_output_driver_enable};
    `CHK("oe", 4'h1, v);
    v = {pin2_pull_up, pin2_pull_down, pin1_pull_up, pin1_pull_down};
    `CHK("pulls", 4'h5, v);
    v = {2'h0, pin2_input_buffer_enable, pin1_input_buffer_enable};
    `CHK("ibuf", 4'h0, v);
    rd_chk(`GPC_OFS_PIN1_CFG, 8'h05, "pin1 cfg reset");
    rd_chk(`GPC_OFS_PIN2_CFG, 8'h04, "pin2 cfg reset");
    rd_chk(`GPC_OFS_DRIVE, 8'h00, "drive reset");
    // every function code on both pins, random fields and sources
    for (int k = 0; k < 16; k++) begin
      a = lfsr(a);
      b = lfsr(a);
      a = lfsr(b);
      c1 = {k[3:0], a[1:0], a[3] & ~a[2], a[2]};
      c2 = {~k[3:0], a[5:4], a[6] & ~a[7], a[7]};
      wd = b[7:0];
      wr(`GPC_OFS_DRIVE, wd);
      wr(`GPC_OFS_PIN1_CFG, c1);
      wr(`GPC_OFS_PIN2_CFG, c2);
      power_on_reset <= b[8];
      pll_locked <= b[9];
      lane_signal_lost <= b[14:10];
      {transmit_clock_input, parallel_clock, serializer_clock} <= a[10:8];
      ext_en <= {~c2[0], ~c1[0]};
      ext_val <= a[12:11];
      pin0_in <= a[13];
      pin0_input_enable <= a[14];
      wr(`GPC_OFS_READBACK, 8'hFF);
      wr(8'h07, 8'hFF);
      repeat (4) @(posedge clock);
      #1;
      e1 = exp_p1(c1[7:4], wd[1], b[8], b[9], b[14:10]);
      e2 = exp_p2(c2[7:4], wd[2], a[10:8]);
      `CHK("pin1 out", e1, pin1_out);
      `CHK("pin2 out", e2, pin2_out);
      v = {pin2_pull_up, pin2_pull_down, pin1_pull_up, pin1_pull_down};
      `CHK("pin1 pulls", exp_pull(c1[3:2]), v[1:0]);
      `CHK("pin2 pulls", exp_pull(c2[3:2]), v[3:2]);
      v = {pin2_input_buffer_enable, pin2_output_driver_enable,
           pin1_input_buffer_enable, pin1_output_driver_enable};
      `CHK("pin1 ib oe", c1[1:0], v[1:0]);
      `CHK("pin2 ib oe", c2[1:0], v[3:2]);
      p1 = c1[0] ? e1 : a[11];
      p2 = c2[0] ? e2 : a[12];
      d = {5'h00, c2[1] & p2, c1[1] & p1, a[14] & a[13]};
      rd_chk(`GPC_OFS_READBACK, d, "readback");
      rd_chk(`GPC_OFS_PIN1_CFG, c1, "pin1 cfg");
      rd_chk(`GPC_OFS_PIN2_CFG, c2, "pin2 cfg");
      rd_chk(`GPC_OFS_DRIVE, {5'h00, wd[2:0]}, "drive");
    end
    rd_chk(8'h07, 8'h00, "unmapped");
    // write then read in the very next cycle; upper bits dropped
    reg_addr <= `GPC_OFS_DRIVE;
    reg_wdata <= 8'hFA;
    reg_wr_en <= 1'b1;
    @(posedge clock); #1;
    reg_wr_en <= 1'b0;
    reg_rd_en <= 1'b1;
    @(posedge clock); #1;
    reg_rd_en <= 1'b0;
    `CHK("drive b2b", 8'h02, reg_rdata);
    @(posedge clock); #1;
    // second reset in mid-run
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    #1 sys_rst <= 1'b0;
    rd_chk(`GPC_OFS_PIN1_CFG, 8'h05, "pin1 cfg re-reset");
    rd_chk(`GPC_OFS_DRIVE, 8'h00, "drive re-reset");
    wrap_up();
  end
endmodule : general_purpose_pin_config_bench
`default_nettype wire
